// file: ismp_core.sv
// Interrupt in-service tracking, masking, priority floor and poll.
// Assumes request latches and source priorities arrive from neighbours.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module ismp_core #(
   parameter int NSRC_P = 11
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [NSRC_P-1:0]      src_req,
   input  wire logic [3*NSRC_P-1:0]    src_prio,
   input  wire logic [NSRC_P-1:0]      ctl_mask_wr,
   input  wire logic [NSRC_P-1:0]      ctl_mask_val,
   input  wire logic                   core_take,
   input  wire logic                   nested_mode,
   output logic      [NSRC_P-1:0]      source_mask_bit,
   output logic                        core_irq,
   output logic      [4:0]             core_type
);
   initial begin
      if (NSRC_P != ismp_pkg::NSRC) $error("ismp_core serves eleven sources only");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [NSRC_P-1:0]  service_flag_q;
   logic [NSRC_P-1:0]  mask_q;
   logic [2:0]         floor_q;
   logic               slave_mode_q;
   logic [NSRC_P-1:0]  eligible;
   logic               any_pend;
   logic [3:0]         top_idx;
   logic               svc_any;
   logic [3:0]         svc_top;
   logic [NSRC_P-1:0]  valid_bits;
   ismp_pkg::ismp_query_s query;

   function automatic logic [7:0] word_idx(input logic [31:0] a);
      word_idx = a[9:2];
   endfunction

   function automatic logic [4:0] type_of(input logic [3:0] i);
      type_of = ismp_pkg::TYPE_BASE + {1'b0, i};
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic       acc;
   logic       wr;
   logic       rd;
   logic [7:0] idx;
   logic       mapped;
   assign acc    = psel && penable;
   assign wr     = acc && pwrite;
   assign rd     = acc && !pwrite;
   assign idx    = word_idx(paddr);
   assign mapped = idx inside {ismp_pkg::IDX_ACK_QUERY, ismp_pkg::IDX_QUERY_STAT,
                               ismp_pkg::IDX_SOURCE_MASK, ismp_pkg::IDX_PRIO_FLOOR,
                               ismp_pkg::IDX_IN_SERVICE, ismp_pkg::IDX_END_SERVICE,
                               ismp_pkg::IDX_MODE};

   assign valid_bits = slave_mode_q ? ismp_pkg::SLAVE_BITS : ismp_pkg::MASTER_BITS;

   // ----------------------------------------------------------------
   // Arbitration: lowest code wins, then lowest index
   // ----------------------------------------------------------------
   always_comb begin
      logic [2:0] best;
      logic [2:0] sbest;
      best     = 3'h7;
      sbest    = 3'h7;
      any_pend = 1'b0;
      top_idx  = 4'h0;
      svc_any  = 1'b0;
      svc_top  = 4'h0;
      for (int i = 0; i < NSRC_P; i++) begin
         eligible[i] = valid_bits[i] && src_req[i] && !mask_q[i]
                       && (src_prio[3*i +: 3] <= floor_q)
                       && (!service_flag_q[i]
                           || (nested_mode && !slave_mode_q && (i == 4 || i == 5)));
      end
      for (int i = NSRC_P-1; i >= 0; i--) begin
         if (eligible[i] && (!any_pend || src_prio[3*i +: 3] <= best)) begin
            any_pend = 1'b1;
            best     = src_prio[3*i +: 3];
            top_idx  = 4'(i);
         end
         if (service_flag_q[i] && (!svc_any || src_prio[3*i +: 3] <= sbest)) begin
            svc_any = 1'b1;
            sbest   = src_prio[3*i +: 3];
            svc_top = 4'(i);
         end
      end
   end

   assign query.pending_flag       = any_pend;
   assign query.pending_type_field = any_pend ? type_of(top_idx) : 5'h00;

   logic poll_ack;
   assign poll_ack = rd && (idx == ismp_pkg::IDX_ACK_QUERY) && any_pend;
   logic take;
   assign take = poll_ack || (core_take && any_pend);

   // ----------------------------------------------------------------
   // Mode, floor and shared mask
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_mode_q <= 1'b0;
      end else if (wr && idx == ismp_pkg::IDX_MODE) begin
         slave_mode_q <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         floor_q <= ismp_pkg::FLOOR_RST;
      end else if (wr && idx == ismp_pkg::IDX_PRIO_FLOOR) begin
         floor_q <= pwdata[ismp_pkg::FLOOR_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= ismp_pkg::MASK_RST_MASTER;
      end else if (wr && idx == ismp_pkg::IDX_MODE) begin
         mask_q <= pwdata[0] ? ismp_pkg::MASK_RST_SLAVE : ismp_pkg::MASK_RST_MASTER;
      end else if (wr && idx == ismp_pkg::IDX_SOURCE_MASK) begin
         mask_q <= pwdata[NSRC_P-1:0] & valid_bits;
      end else begin
         mask_q <= ((mask_q & ~ctl_mask_wr) | (ctl_mask_val & ctl_mask_wr)) & valid_bits;
      end
   end

   // ----------------------------------------------------------------
   // In-service flags; a set wins over a clear in the same cycle, except a mode write, which clears all
   // ----------------------------------------------------------------
   logic [NSRC_P-1:0] set_v;
   logic [NSRC_P-1:0] clr_v;
   logic              eos_wr;
   always_comb begin
      set_v  = '0;
      clr_v  = '0;
      eos_wr = wr && idx == ismp_pkg::IDX_END_SERVICE && !slave_mode_q;
      // Slave flags are set by the internal requests themselves and held until core_take
      if (slave_mode_q) begin
         set_v = src_req & valid_bits;
      end
      if (take) begin
         set_v[top_idx] = 1'b1;
      end
      if (eos_wr) begin
         if (pwdata[ismp_pkg::GENERIC_END_BIT]) begin
            if (svc_any) clr_v[svc_top] = 1'b1;
         end else begin
            for (int i = 0; i < NSRC_P; i++) begin
               if (pwdata[4:0] == type_of(4'(i))) clr_v[i] = 1'b1;
            end
         end
      end
      if (slave_mode_q && core_take) begin
         clr_v = service_flag_q & ~set_v;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         service_flag_q <= '0;
      end else if (wr && idx == ismp_pkg::IDX_MODE) begin
         service_flag_q <= '0;
      end else begin
         service_flag_q <= ((service_flag_q & ~clr_v) | set_v) & valid_bits;
      end
   end

   // ----------------------------------------------------------------
   // Read mux and outputs (all registered)
   // ----------------------------------------------------------------
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      case (idx)
         ismp_pkg::IDX_ACK_QUERY,
         ismp_pkg::IDX_QUERY_STAT:  rd_d = {16'h0000, query.pending_flag, 10'h000,
                                           query.pending_type_field};
         ismp_pkg::IDX_SOURCE_MASK: rd_d = {21'h00_0000, mask_q};
         ismp_pkg::IDX_PRIO_FLOOR:  rd_d = {29'h0000_0000, floor_q};
         ismp_pkg::IDX_IN_SERVICE:  rd_d = {21'h00_0000, service_flag_q};
         ismp_pkg::IDX_MODE:        rd_d = {31'h0000_0000, slave_mode_q};
         default:                   rd_d = 32'h0000_0000;
      endcase
   end

   // Zero-wait slave: pready pulses in the access cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_mask_bit <= ismp_pkg::MASK_RST_MASTER;
         core_irq        <= 1'b0;
         core_type       <= 5'h00;
      end else begin
         source_mask_bit <= mask_q;
         core_irq        <= any_pend;
         core_type       <= query.pending_type_field;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_floor_reset: assert property (@(posedge pclk) $rose(presetn) |-> floor_q == 3'h7)
      else $error("floor not seven after reset");
   a_floor_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      (src_prio[2:0] > floor_q) |-> !eligible[0])
      else $error("request above floor allowed");
   a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      mask_q[0] |-> !eligible[0])
      else $error("masked source allowed");
   a_poll_sets: assert property (@(posedge pclk) disable iff (!presetn)
      poll_ack && !wr |=> service_flag_q[$past(top_idx)])
      else $error("poll acknowledge did not set flag");
   a_status_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      rd && idx == ismp_pkg::IDX_QUERY_STAT && !core_take |=> $stable(service_flag_q))
      else $error("status read changed state");
   a_pend_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 core_irq == $past(|eligible))
      else $error("pending flag wrong");
   a_slave_bits: assert property (@(posedge pclk) disable iff (!presetn)
      slave_mode_q |-> (service_flag_q & ~ismp_pkg::SLAVE_BITS) == '0)
      else $error("slave flag outside layout");
   a_eos_clear: assert property (@(posedge pclk) disable iff (!presetn)
      eos_wr && !pwdata[15] && pwdata[4:0] == 5'h08 && !set_v[0] |=> !service_flag_q[0])
      else $error("specific end did not clear");
   a_slave_set: assert property (@(posedge pclk) disable iff (!presetn)
      slave_mode_q && src_req[2] && !wr |=> service_flag_q[2])
      else $error("slave request did not set flag");
   a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready || (psel && !penable))
      else $error("pready not single cycle");
endmodule

// file: ismp_pkg.sv
// Package for the in-service, mask and polled acknowledge block.
// Assumes an APB slave with 32-bit data; one clock, pclk.
package ismp_pkg;
   // ----------------------------------------------------------------
   // Register offsets (printed offsets are not all word multiples)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_ACK_QUERY   = 8'h24;
   localparam logic [7:0] IDX_QUERY_STAT  = 8'h26;
   localparam logic [7:0] IDX_SOURCE_MASK = 8'h28;
   localparam logic [7:0] IDX_PRIO_FLOOR  = 8'h2a;
   localparam logic [7:0] IDX_IN_SERVICE  = 8'h2c;
   localparam logic [7:0] IDX_END_SERVICE = 8'h22;
   localparam logic [7:0] IDX_MODE        = 8'h30;
   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int          NSRC            = 11;
   localparam int          PENDING_BIT     = 15;
   localparam int          GENERIC_END_BIT = 15;
   localparam int          TYPE_W          = 5;
   localparam int          FLOOR_W         = 3;
   localparam logic [10:0] MASTER_BITS     = 11'h7fd;
   localparam logic [10:0] SLAVE_BITS      = 11'h03d;
   localparam logic [10:0] MASK_RST_MASTER = 11'h7fd;
   localparam logic [10:0] MASK_RST_SLAVE  = 11'h03d;
   localparam logic [2:0]  FLOOR_RST       = 3'h7;
   localparam logic [4:0]  TYPE_BASE       = 5'h08;

   typedef struct packed {
      logic                pending_flag;
      logic [TYPE_W-1:0]   pending_type_field;
   } ismp_query_s;
endpackage

// file: ismp_partner.sv
// Model of the request sources, control-register mask writes and core.
// Assumes the bench steers it through command inputs sampled on pclk.
`timescale 1ns/1ns
module ismp_partner (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [10:0] req_cmd,
   input  wire logic [32:0] prio_cmd,
   input  wire logic [10:0] mask_wr_cmd,
   input  wire logic [10:0] mask_val_cmd,
   input  wire logic        take_cmd,
   input  wire logic        nest_cmd,
   output logic      [10:0] src_req,
   output logic      [32:0] src_prio,
   output logic      [10:0] ctl_mask_wr,
   output logic      [10:0] ctl_mask_val,
   output logic             core_take,
   output logic             nested_mode
);
   // ----------------------------------------------------------------
   // Sources and core
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_req      <= 11'h000;
         src_prio     <= 33'h1_ffff_ffff;
         ctl_mask_wr  <= 11'h000;
         ctl_mask_val <= 11'h000;
         core_take    <= 1'h0;
         nested_mode  <= 1'h0;
      end else begin
         nested_mode  <= nest_cmd;
         src_req      <= req_cmd;
         src_prio     <= prio_cmd;
         ctl_mask_wr  <= mask_wr_cmd;
         ctl_mask_val <= mask_val_cmd;
         // Acknowledge only; no vector fetch follows it
         core_take    <= take_cmd;
      end
   end
endmodule

// file: ismp_tb.sv
// Self-checking bench for the in-service, mask and poll block.
// Assumes ismp_core and ismp_partner are compiled before it.
`timescale 1ns/1ns
module ismp_tb;
   typedef struct {
      logic [7:0]  idx;
      logic        wr;
      logic [31:0] wd;
      logic [31:0] exp;
      logic        err;
   } ismp_row_s;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [10:0] src_req, ctl_mask_wr, ctl_mask_val, source_mask_bit;
   logic [32:0] src_prio;
   logic        core_take, nested_mode, core_irq;
   logic [4:0]  core_type;
   logic [10:0] req_cmd = 11'h000;
   logic [32:0] prio_cmd = 33'h1_ffff_ffff;
   logic [10:0] mwr_cmd = 11'h000;
   logic [10:0] mval_cmd = 11'h000;
   logic        take_cmd = 1'h0;
   logic        nest_cmd = 1'h0;
   int          fails = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   logic [31:0] rd;
   logic        er;
   ismp_row_s   rows[9] = '{
      '{ismp_pkg::IDX_SOURCE_MASK, 1'h0, 32'h0000_0000, 32'h0000_07fd, 1'h0},
      '{ismp_pkg::IDX_PRIO_FLOOR,  1'h0, 32'h0000_0000, 32'h0000_0007, 1'h0},
      '{ismp_pkg::IDX_IN_SERVICE,  1'h0, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{ismp_pkg::IDX_QUERY_STAT,  1'h0, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{ismp_pkg::IDX_PRIO_FLOOR,  1'h1, 32'hffff_fffc, 32'h0000_0000, 1'h0},
      '{ismp_pkg::IDX_PRIO_FLOOR,  1'h0, 32'h0000_0000, 32'h0000_0004, 1'h0},
      '{ismp_pkg::IDX_SOURCE_MASK, 1'h1, 32'hffff_f800, 32'h0000_0000, 1'h0},
      '{ismp_pkg::IDX_SOURCE_MASK, 1'h0, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{8'h01,                     1'h0, 32'h0000_0000, 32'h0000_0000, 1'h1}};

   ismp_core ismp_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .src_prio(src_prio), .ctl_mask_wr(ctl_mask_wr),
      .ctl_mask_val(ctl_mask_val), .core_take(core_take), .nested_mode(nested_mode),
      .source_mask_bit(source_mask_bit), .core_irq(core_irq), .core_type(core_type));
   ismp_partner ismp_partner_i (.pclk(pclk), .presetn(presetn), .req_cmd(req_cmd),
      .prio_cmd(prio_cmd), .mask_wr_cmd(mwr_cmd), .mask_val_cmd(mval_cmd),
      .take_cmd(take_cmd), .nest_cmd(nest_cmd), .src_req(src_req), .src_prio(src_prio),
      .ctl_mask_wr(ctl_mask_wr), .ctl_mask_val(ctl_mask_val), .core_take(core_take),
      .nested_mode(nested_mode));

   // ----------------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------------
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic apb(input logic [7:0] i, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {22'h00_0000, i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) fails++;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Slack so registered status settles before the next look
      repeat (3) @(posedge pclk);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [31:0] e);
      apb(i, 1'h0, 32'h0000_0000);
      chk($sformatf("reg %h", i), rd, e);
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[k]) begin
         apb(rows[k].idx, rows[k].wr, rows[k].wd);
         if (!rows[k].wr) chk("rdata", rd, rows[k].exp);
         chk("pslverr", {31'h0, er}, {31'h0, rows[k].err});
      end
      chk("mask port", {21'h0, source_mask_bit}, 32'h0000_0000);
      apb(ismp_pkg::IDX_PRIO_FLOOR, 1'h1, 32'h0000_0007);
      prio_cmd[2:0] <= 3'h4;
      prio_cmd[11:9] <= 3'h2;
      prio_cmd[17:15] <= 3'h1;
      req_cmd <= 11'h029;
      repeat (4) @(posedge pclk);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_800d);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_800d);
      chk("core irq", {31'h0, core_irq}, 32'h0000_0001);
      chk("core type", {27'h0, core_type}, 32'h0000_000d);
      rdc(ismp_pkg::IDX_ACK_QUERY, 32'h0000_800d);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0020);
      rdc(ismp_pkg::IDX_ACK_QUERY, 32'h0000_800b);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0028);
      apb(ismp_pkg::IDX_END_SERVICE, 1'h1, 32'h0000_000d);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0008);
      rdc(ismp_pkg::IDX_ACK_QUERY, 32'h0000_800d);
      apb(ismp_pkg::IDX_END_SERVICE, 1'h1, 32'h0000_8000);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0008);
      apb(ismp_pkg::IDX_END_SERVICE, 1'h1, 32'h0000_000b);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0000);
      apb(ismp_pkg::IDX_PRIO_FLOOR, 1'h1, 32'h0000_0000);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_0000);
      apb(ismp_pkg::IDX_PRIO_FLOOR, 1'h1, 32'h0000_0001);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_800d);
      mwr_cmd <= 11'h020;
      mval_cmd <= 11'h020;
      @(posedge pclk);
      mwr_cmd <= 11'h000;
      rdc(ismp_pkg::IDX_SOURCE_MASK, 32'h0000_0020);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_0000);
      apb(ismp_pkg::IDX_PRIO_FLOOR, 1'h1, 32'h0000_0002);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_800b);
      apb(ismp_pkg::IDX_SOURCE_MASK, 1'h1, 32'h0000_07fd);
      chk("mask port", {21'h0, source_mask_bit}, 32'h0000_07fd);
      rdc(ismp_pkg::IDX_QUERY_STAT, 32'h0000_0000);
      chk("core irq", {31'h0, core_irq}, 32'h0000_0000);
      req_cmd <= 11'h010;
      nest_cmd <= 1'h1;
      apb(ismp_pkg::IDX_SOURCE_MASK, 1'h1, 32'h0000_0000);
      apb(ismp_pkg::IDX_PRIO_FLOOR, 1'h1, 32'h0000_0007);
      rdc(ismp_pkg::IDX_ACK_QUERY, 32'h0000_800c);
      rdc(ismp_pkg::IDX_ACK_QUERY, 32'h0000_800c);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0010);
      apb(ismp_pkg::IDX_END_SERVICE, 1'h1, 32'h0000_8000);
      nest_cmd <= 1'h0;
      req_cmd <= 11'h000;
      apb(ismp_pkg::IDX_MODE, 1'h1, 32'h0000_0001);
      rdc(ismp_pkg::IDX_SOURCE_MASK, 32'h0000_003d);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0000);
      apb(ismp_pkg::IDX_SOURCE_MASK, 1'h1, 32'h0000_0000);
      req_cmd <= 11'h014;
      repeat (3) @(posedge pclk);
      req_cmd <= 11'h000;
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0014);
      apb(ismp_pkg::IDX_IN_SERVICE, 1'h1, 32'h0000_ffff);
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0014);
      take_cmd <= 1'h1;
      @(posedge pclk);
      take_cmd <= 1'h0;
      rdc(ismp_pkg::IDX_IN_SERVICE, 32'h0000_0000);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rdc(ismp_pkg::IDX_SOURCE_MASK, 32'h0000_07fd);
      rdc(ismp_pkg::IDX_PRIO_FLOOR, 32'h0000_0007);
      end_sim();
   end
endmodule
